// ===== perf_monitor_event_select.sv
/*
 * two performance counters with event selection and an apb slave.
 * assumes event sources are logic on clk, one strobe per event per cycle,
 * and an apb master that holds each request until pready is seen high.
 * counter widths are fixed at 32 bits to match the apb data word.
 */
// Overview of operation
// - first counter, code 28: single-beat read acks
// - first counter, code 37: guarded-load address stall cycles
// - second counter, code 5: not-taken branches
// - second counter, code 7: simple vector completions
// - second counter, code 8: complex vector completions
// - second counter, code 15: queued load misses, no mmu
// - second counter, code 19: l2 read beats
// - pipelined burst drive cycle not counted
// - second counter, code 21: multi-beat read acks
`timescale 1ns/1ps
module perf_monitor_event_select (
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources
    input wire logic ack_single_read,
    input wire logic guard_stall,
    input wire logic branch_not_taken,
    input wire logic [1:0] simple_vec_done,
    input wire logic [1:0] complex_vec_done,
    input wire logic load_miss_queued,
    input wire logic load_miss_mmu,
    input wire logic l2_read_beat,
    input wire logic l2_read_drive,
    input wire logic ack_multi_read,
    // counter values and l2 settings for the surrounding logic
    output logic [31:0] first_perf_counter,
    output logic [31:0] second_perf_counter,
    output logic [1:0] l2_data_bus_width,
    output logic pipelined_burst_sram_mode
);
    // whole module state in one record
    typedef struct packed {
        logic [31:0] first_cnt; // first counter value
        logic [31:0] second_cnt; // second counter value
        logic [6:0] sel1; // first event select
        logic [5:0] sel2; // second event select
        logic [1:0] bus_w; // l2 data bus width field
        logic burst_mode; // pipelined burst sram mode
        logic [31:0] rdata; // registered read data
        logic ready; // access-phase answer
        logic err; // unmapped address answer
    } state_t;

    state_t st_r; // current state
    state_t st_nxt; // next state
    logic [1:0] inc1; // first counter increment
    logic [1:0] inc2; // second counter increment
    logic access; // apb access phase
    logic mapped; // address hits a register
    logic wr_take; // write completes this edge
    logic wr_first; // write to first counter
    logic wr_second; // write to second counter

    // first counter event decode
    first_event_decode u_first (
        .sel(st_r.sel1),
        .ack_single_read(ack_single_read),
        .guard_stall(guard_stall),
        .inc(inc1)
    );

    // second counter event decode
    second_event_decode u_second (
        .sel(st_r.sel2),
        .branch_not_taken(branch_not_taken),
        .simple_vec_done(simple_vec_done),
        .complex_vec_done(complex_vec_done),
        .load_miss_queued(load_miss_queued),
        .load_miss_mmu(load_miss_mmu),
        .l2_read_beat(l2_read_beat),
        .l2_read_drive(l2_read_drive),
        .bus_width(st_r.bus_w),
        .pipelined_burst_sram_mode(st_r.burst_mode),
        .ack_multi_read(ack_multi_read),
        .inc(inc2)
    );

    // address decode and write strobes
    always_comb
    begin
        access = psel && penable;
        mapped = (paddr == perf_pkg::OFS_FIRST_CNT) || (paddr == perf_pkg::OFS_SECOND_CNT)
            || (paddr == perf_pkg::OFS_EVENT_SEL) || (paddr == perf_pkg::OFS_L2_CTRL);
        // an unmapped address answers with pslverr and drops the write
        // writes land only at the edge that samples pready high
        wr_take = access && st_r.ready && pwrite && mapped;
        wr_first = wr_take && (paddr == perf_pkg::OFS_FIRST_CNT);
        wr_second = wr_take && (paddr == perf_pkg::OFS_SECOND_CNT);
    end

    // next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // one wait state lets read data come from flops
        st_nxt.ready = access && !st_r.ready;
        st_nxt.err = access && !st_r.ready && !mapped;
        // rdata is loaded in the first access cycle of reads and writes alike, and holds between accesses
        if (access && !st_r.ready)
        begin
            unique case (paddr)
                perf_pkg::OFS_FIRST_CNT: st_nxt.rdata = st_r.first_cnt;
                perf_pkg::OFS_SECOND_CNT: st_nxt.rdata = st_r.second_cnt;
                perf_pkg::OFS_EVENT_SEL: st_nxt.rdata = {18'h0, st_r.sel2, 1'h0, st_r.sel1};
                perf_pkg::OFS_L2_CTRL: st_nxt.rdata = {29'h0, st_r.burst_mode, st_r.bus_w};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // counters add only their selected event's amount
        st_nxt.first_cnt = st_r.first_cnt + {30'h0, inc1};
        st_nxt.second_cnt = st_r.second_cnt + {30'h0, inc2};
        // a software preset beats the event in the same cycle
        if (wr_first)
        begin
            st_nxt.first_cnt = pwdata;
        end
        if (wr_second)
        begin
            st_nxt.second_cnt = pwdata;
        end
        // select and l2 control fields
        if (wr_take && (paddr == perf_pkg::OFS_EVENT_SEL))
        begin
            st_nxt.sel1 = pwdata[perf_pkg::SEL1_LSB +: perf_pkg::SEL1_W];
            st_nxt.sel2 = pwdata[perf_pkg::SEL2_LSB +: perf_pkg::SEL2_W];
        end
        if (wr_take && (paddr == perf_pkg::OFS_L2_CTRL))
        begin
            st_nxt.bus_w = pwdata[perf_pkg::BUS_W_LSB +: 2];
            st_nxt.burst_mode = pwdata[perf_pkg::BURST_MODE_BIT];
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // every field returns to its package reset value
            st_r.first_cnt <= perf_pkg::CNT_RST;
            st_r.second_cnt <= perf_pkg::CNT_RST;
            st_r.sel1 <= perf_pkg::SEL1_RST;
            st_r.sel2 <= perf_pkg::SEL2_RST;
            st_r.bus_w <= perf_pkg::BUS_W_RST;
            st_r.burst_mode <= perf_pkg::BURST_MODE_RST;
            st_r.rdata <= perf_pkg::RDATA_RST;
            st_r.ready <= perf_pkg::FLAG_RST;
            st_r.err <= perf_pkg::FLAG_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the record
    // no logic between the flops and the pins
    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.err;
    assign first_perf_counter = st_r.first_cnt;
    assign second_perf_counter = st_r.second_cnt;
    assign l2_data_bus_width = st_r.bus_w;
    assign pipelined_burst_sram_mode = st_r.burst_mode;

    // checks on counter behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // every check but the two preset checks skips the edge at which software presets the counter
    chk_first_single_read: assert property (
        (st_r.sel1 == perf_pkg::EV1_ACK_SINGLE_READ && ack_single_read && !wr_first)
        |=> first_perf_counter == $past(first_perf_counter) + 32'h1)
        else $error("first counter missed a single-beat read ack");

    // a level: one count per stalled bus cycle
    chk_guard_stall: assert property (
        (st_r.sel1 == perf_pkg::EV1_GUARD_STALL && !wr_first)
        |=> first_perf_counter == $past(first_perf_counter) + {31'h0, $past(guard_stall)})
        else $error("first counter wrong on guarded-load stall");

    chk_fall_through: assert property (
        (st_r.sel2 == perf_pkg::EV2_FALL_THROUGH && branch_not_taken && !wr_second)
        |=> second_perf_counter == $past(second_perf_counter) + 32'h1)
        else $error("second counter missed a not-taken branch");

    chk_simple_vec: assert property (
        (st_r.sel2 == perf_pkg::EV2_SIMPLE_VEC && !wr_second)
        |=> second_perf_counter == $past(second_perf_counter) + {30'h0, $past(simple_vec_done)})
        else $error("second counter wrong for simple vector completions");

    chk_complex_vec: assert property (
        (st_r.sel2 == perf_pkg::EV2_COMPLEX_VEC && !wr_second)
        |=> second_perf_counter == $past(second_perf_counter) + {30'h0, $past(complex_vec_done)})
        else $error("second counter wrong for complex vector completions");

    // mmu-tagged misses never reach the counter
    chk_mmu_excluded: assert property (
        (st_r.sel2 == perf_pkg::EV2_L1_LOAD_MISS && load_miss_mmu && !wr_second)
        |=> $stable(second_perf_counter))
        else $error("second counter counted an mmu miss");

    chk_l2_beat: assert property (
        (st_r.sel2 == perf_pkg::EV2_L2_READ_BEAT && l2_read_beat && !st_r.burst_mode
        && st_r.bus_w == perf_pkg::BUS_W_32 && !wr_second)
        |=> second_perf_counter == $past(second_perf_counter) + 32'h1)
        else $error("second counter missed an l2 read beat");

    // the drive cycle of pipelined burst parts carries no data
    chk_drive_skipped: assert property (
        (st_r.sel2 == perf_pkg::EV2_L2_READ_BEAT && st_r.burst_mode && l2_read_drive
        && !wr_second)
        |=> $stable(second_perf_counter))
        else $error("second counter counted the read drive cycle");

    chk_multi_read: assert property (
        (st_r.sel2 == perf_pkg::EV2_ACK_MULTI_READ && ack_multi_read && !wr_second)
        |=> second_perf_counter == $past(second_perf_counter) + 32'h1)
        else $error("second counter missed a multi-beat read ack");

    chk_unlisted_hold: assert property (
        (st_r.sel1 != perf_pkg::EV1_ACK_SINGLE_READ && st_r.sel1 != perf_pkg::EV1_GUARD_STALL
        && !wr_first) |=> $stable(first_perf_counter))
        else $error("first counter moved on an unlisted code");

    // the second counter idles on codes it does not know
    chk_second_unlisted: assert property (
        (st_r.sel2 != perf_pkg::EV2_FALL_THROUGH && st_r.sel2 != perf_pkg::EV2_SIMPLE_VEC
        && st_r.sel2 != perf_pkg::EV2_COMPLEX_VEC && st_r.sel2 != perf_pkg::EV2_L1_LOAD_MISS
        && st_r.sel2 != perf_pkg::EV2_L2_READ_BEAT && st_r.sel2 != perf_pkg::EV2_ACK_MULTI_READ
        && !wr_second) |=> $stable(second_perf_counter))
        else $error("second counter moved on an unlisted code");

    // no acknowledge, no count: catches a stuck or inverted strobe
    chk_single_read_idle: assert property (
        (st_r.sel1 == perf_pkg::EV1_ACK_SINGLE_READ && !ack_single_read && !wr_first)
        |=> $stable(first_perf_counter))
        else $error("first counter moved without a single-beat read ack");

    chk_guard_idle: assert property (
        (st_r.sel1 == perf_pkg::EV1_GUARD_STALL && !guard_stall && !wr_first)
        |=> $stable(first_perf_counter))
        else $error("first counter moved without a guarded-load stall");

    chk_branch_idle: assert property (
        (st_r.sel2 == perf_pkg::EV2_FALL_THROUGH && !branch_not_taken && !wr_second)
        |=> $stable(second_perf_counter))
        else $error("second counter moved without a not-taken branch");

    // a real miss outside mmu traffic adds exactly one
    chk_load_miss_count: assert property (
        (st_r.sel2 == perf_pkg::EV2_L1_LOAD_MISS && load_miss_queued && !load_miss_mmu
        && !wr_second) |=> second_perf_counter == $past(second_perf_counter) + 32'h1)
        else $error("second counter missed a queued load miss");

    // wide bus beats count the same as narrow ones
    chk_l2_beat_wide: assert property (
        (st_r.sel2 == perf_pkg::EV2_L2_READ_BEAT && l2_read_beat && !st_r.burst_mode
        && st_r.bus_w == perf_pkg::BUS_W_64 && !wr_second)
        |=> second_perf_counter == $past(second_perf_counter) + 32'h1)
        else $error("second counter missed a wide l2 read beat");

    // reserved width codes leave the beat count frozen
    chk_reserved_width: assert property (
        (st_r.sel2 == perf_pkg::EV2_L2_READ_BEAT && st_r.bus_w != perf_pkg::BUS_W_64
        && st_r.bus_w != perf_pkg::BUS_W_32 && !wr_second)
        |=> $stable(second_perf_counter))
        else $error("second counter counted on a reserved bus width");

    // burst mode only drops the drive cycle, not the data beats
    chk_burst_beat: assert property (
        (st_r.sel2 == perf_pkg::EV2_L2_READ_BEAT && st_r.burst_mode && l2_read_beat
        && !l2_read_drive && st_r.bus_w == perf_pkg::BUS_W_32 && !wr_second)
        |=> second_perf_counter == $past(second_perf_counter) + 32'h1)
        else $error("second counter dropped a beat in burst mode");

    chk_multi_idle: assert property (
        (st_r.sel2 == perf_pkg::EV2_ACK_MULTI_READ && !ack_multi_read && !wr_second)
        |=> $stable(second_perf_counter))
        else $error("second counter moved without a multi-beat read ack");

    // a software preset replaces the value, whatever the event does
    chk_first_preset: assert property (
        wr_first |=> first_perf_counter == $past(pwdata))
        else $error("first counter ignored a software preset");

    chk_second_preset: assert property (
        wr_second |=> second_perf_counter == $past(pwdata))
        else $error("second counter ignored a software preset");
endmodule

// ===== perf_pkg.sv
/*
 * constants for the performance monitor event selection block:
 * register offsets, field positions, reset values and event codes.
 * assumes a 32-bit apb register bus and event sources on the core clock.
 */
package perf_pkg;
    // widths
    localparam int CNT_W = 32;
    localparam int SEL1_W = 7;
    localparam int SEL2_W = 6;
    localparam int INC_W = 2;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_FIRST_CNT = 8'h00;
    localparam logic [7:0] OFS_SECOND_CNT = 8'h04;
    localparam logic [7:0] OFS_EVENT_SEL = 8'h08;
    localparam logic [7:0] OFS_L2_CTRL = 8'h0C;

    // field positions
    localparam int SEL1_LSB = 0;
    localparam int SEL2_LSB = 8;
    localparam int BUS_W_LSB = 0;
    localparam int BURST_MODE_BIT = 2;

    // reset values
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [6:0] SEL1_RST = 7'h00;
    localparam logic [5:0] SEL2_RST = 6'h00;
    localparam logic [1:0] BUS_W_RST = 2'h0;
    localparam logic BURST_MODE_RST = 1'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic FLAG_RST = 1'h0;

    // first counter event codes
    localparam logic [6:0] EV1_ACK_SINGLE_READ = 7'h1C;
    localparam logic [6:0] EV1_GUARD_STALL = 7'h25;

    // second counter event codes
    localparam logic [5:0] EV2_FALL_THROUGH = 6'h05;
    localparam logic [5:0] EV2_SIMPLE_VEC = 6'h07;
    localparam logic [5:0] EV2_COMPLEX_VEC = 6'h08;
    localparam logic [5:0] EV2_L1_LOAD_MISS = 6'h0F;
    localparam logic [5:0] EV2_L2_READ_BEAT = 6'h13;
    localparam logic [5:0] EV2_ACK_MULTI_READ = 6'h15;

    // l2 data bus width codes
    localparam logic [1:0] BUS_W_64 = 2'h0;
    localparam logic [1:0] BUS_W_32 = 2'h2;
endpackage

// ===== first_event_decode.sv
/*
 * increment decode for the first performance counter.
 * assumes event strobes are one-cycle levels on the core clock.
 */
`timescale 1ns/1ps
module first_event_decode (
    input wire logic [6:0] sel,
    input wire logic ack_single_read,
    input wire logic guard_stall,
    output logic [1:0] inc
);
    // one of two events, everything else adds nothing
    always_comb
    begin
        inc = 2'h0;
        if (sel == perf_pkg::EV1_ACK_SINGLE_READ)
        begin
            inc = {1'h0, ack_single_read};
        end
        else if (sel == perf_pkg::EV1_GUARD_STALL)
        begin
            inc = {1'h0, guard_stall};
        end
    end
endmodule

// ===== second_event_decode.sv
/*
 * increment decode for the second performance counter.
 * assumes event sources on the core clock; vector counts are 0..3.
 */
`timescale 1ns/1ps
module second_event_decode (
    input wire logic [5:0] sel,
    input wire logic branch_not_taken,
    input wire logic [1:0] simple_vec_done,
    input wire logic [1:0] complex_vec_done,
    input wire logic load_miss_queued,
    input wire logic load_miss_mmu,
    input wire logic l2_read_beat,
    input wire logic l2_read_drive,
    input wire logic [1:0] bus_width,
    input wire logic pipelined_burst_sram_mode,
    input wire logic ack_multi_read,
    output logic [1:0] inc
);
    logic width_ok; // reserved width codes count nothing
    logic beat_ok; // beat qualified against the drive cycle

    // beat qualification
    always_comb
    begin
        width_ok = (bus_width == perf_pkg::BUS_W_64) || (bus_width == perf_pkg::BUS_W_32);
        // drive cycle of pipelined burst parts carries no data
        beat_ok = l2_read_beat && width_ok
            && !(pipelined_burst_sram_mode && l2_read_drive);
    end

    // select decode, unlisted codes add zero
    always_comb
    begin
        inc = 2'h0;
        unique case (sel)
            perf_pkg::EV2_FALL_THROUGH: inc = {1'h0, branch_not_taken};
            perf_pkg::EV2_SIMPLE_VEC: inc = simple_vec_done;
            perf_pkg::EV2_COMPLEX_VEC: inc = complex_vec_done;
            // mmu traffic is not a data load miss
            perf_pkg::EV2_L1_LOAD_MISS: inc = {1'h0, load_miss_queued && !load_miss_mmu};
            perf_pkg::EV2_L2_READ_BEAT: inc = {1'h0, beat_ok};
            perf_pkg::EV2_ACK_MULTI_READ: inc = {1'h0, ack_multi_read};
            default: inc = 2'h0;
        endcase
    end
endmodule

// ===== event_source_model.sv
/*
 * event source model: pipeline, bus unit and l2 strobes for the monitor.
 * assumes the bench sets mask and amt just after rising edges of clk.
 */
`timescale 1ns/1ps
module event_source_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] mask,
    input wire logic [1:0] amt,
    output logic ack_single_read,
    output logic guard_stall,
    output logic branch_not_taken,
    output logic [1:0] simple_vec_done,
    output logic [1:0] complex_vec_done,
    output logic load_miss_queued,
    output logic load_miss_mmu,
    output logic l2_read_beat,
    output logic l2_read_drive,
    output logic ack_multi_read
);
    // every source fires while its mask bit is set; complex count differs from
    // the simple one so that a swapped vector source shows up
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {ack_single_read, guard_stall, branch_not_taken, load_miss_queued} <= 4'h0;
            {load_miss_mmu, l2_read_beat, l2_read_drive, ack_multi_read} <= 4'h0;
            simple_vec_done <= 2'h0;
            complex_vec_done <= 2'h0;
        end
        else
        begin
            {ack_single_read, guard_stall, branch_not_taken} <= mask[2:0];
            {load_miss_queued, load_miss_mmu} <= mask[6:5];
            {ack_multi_read, l2_read_drive, l2_read_beat} <= mask[9:7];
            simple_vec_done <= mask[3] ? amt : 2'h0;
            complex_vec_done <= mask[4] ? 2'h3 - amt : 2'h0;
        end
    end
endmodule

// ===== tb_top.sv
/*
 * self-checking bench for the performance monitor event select block.
 * assumes the apb answer after one wait state and the event source model.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0; // core clock
    logic rst = 1'b1; // async reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err;
    logic [9:0] mask = 10'h000; // event pattern for the model
    logic [1:0] amt = 2'h0; // vector count for the model
    logic ack_s, gst, bnt, lmq, lmm, l2b, l2d, ack_m, bmode;
    logic [1:0] svd, cvd, bw;
    logic [31:0] c1, c2;
    int error_cnt = 0;
    int comparisons = 0;

    // free-running 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    perf_monitor_event_select i_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ack_single_read(ack_s), .guard_stall(gst), .branch_not_taken(bnt),
        .simple_vec_done(svd), .complex_vec_done(cvd), .load_miss_queued(lmq),
        .load_miss_mmu(lmm), .l2_read_beat(l2b), .l2_read_drive(l2d), .ack_multi_read(ack_m),
        .first_perf_counter(c1), .second_perf_counter(c2), .l2_data_bus_width(bw),
        .pipelined_burst_sram_mode(bmode)
    );

    event_source_model i_src (
        .clk(clk), .rst(rst), .mask(mask), .amt(amt),
        .ack_single_read(ack_s), .guard_stall(gst), .branch_not_taken(bnt),
        .simple_vec_done(svd), .complex_vec_done(cvd), .load_miss_queued(lmq),
        .load_miss_mmu(lmm), .l2_read_beat(l2b), .l2_read_drive(l2d), .ack_multi_read(ack_m)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // a transfer that never completes is a mismatch
        if (pready !== 1'b1)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // select, clear counters, fire the pattern five cycles, read both back
    task automatic run_case(input logic [6:0] s1, input logic [5:0] s2, input logic [9:0] m,
        input logic [1:0] a, input logic [2:0] l2c, input int e1, input int e2);
        apb(1'b1, perf_pkg::OFS_EVENT_SEL, {18'h0, s2, 1'b0, s1});
        apb(1'b1, perf_pkg::OFS_L2_CTRL, {29'h0, l2c});
        apb(1'b1, perf_pkg::OFS_FIRST_CNT, perf_pkg::CNT_RST);
        apb(1'b1, perf_pkg::OFS_SECOND_CNT, perf_pkg::CNT_RST);
        @(posedge clk);
        mask <= m;
        amt <= a;
        repeat (5) @(posedge clk);
        mask <= 10'h000;
        // idle cycles let the last increment land before the read
        repeat (3) @(posedge clk);
        apb(1'b0, perf_pkg::OFS_FIRST_CNT, 32'h0);
        check(rd, 32'(e1 * 5));
        apb(1'b0, perf_pkg::OFS_SECOND_CNT, 32'h0);
        check(rd, 32'(e2 * 5));
        // the counter ports must agree with the register reads
        check(c1, 32'(e1 * 5));
        check(c2, 32'(e2 * 5));
    endtask

    // reset values of all registers, then an unmapped read
    task automatic test_reset();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check(rd, 32'h0000_0000);
        end
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
    endtask

    task automatic test_first();
        run_case(7'h1C, 6'h05, 10'h3BF, 2'h2, 3'h0, 1, 1);
        run_case(7'h25, 6'h07, 10'h3BF, 2'h2, 3'h0, 1, 2);
        run_case(7'h25, 6'h15, 10'h001, 2'h0, 3'h0, 0, 0);
    endtask

    task automatic test_vector();
        run_case(7'h7F, 6'h08, 10'h3BF, 2'h2, 3'h0, 0, 1);
        run_case(7'h00, 6'h08, 10'h3BF, 2'h0, 3'h0, 0, 3);
        run_case(7'h1C, 6'h07, 10'h3BF, 2'h3, 3'h0, 1, 3);
    endtask

    // mmu-qualified misses are dropped
    task automatic test_miss();
        run_case(7'h00, 6'h0F, 10'h040, 2'h0, 3'h0, 0, 1);
        run_case(7'h00, 6'h0F, 10'h060, 2'h0, 3'h0, 0, 0);
    endtask

    // drive cycle only suppressed in pipelined burst mode
    task automatic test_beat();
        run_case(7'h00, 6'h13, 10'h080, 2'h0, 3'h0, 0, 1);
        run_case(7'h00, 6'h13, 10'h080, 2'h0, 3'h2, 0, 1);
        run_case(7'h00, 6'h13, 10'h180, 2'h0, 3'h6, 0, 0);
        run_case(7'h00, 6'h13, 10'h080, 2'h0, 3'h6, 0, 1);
        check({31'h0, bmode}, 32'h0000_0001);
        // reserved width code counts nothing
        run_case(7'h00, 6'h13, 10'h080, 2'h0, 3'h1, 0, 0);
        run_case(7'h00, 6'h13, 10'h180, 2'h0, 3'h2, 0, 1);
        check({30'h0, bw}, 32'h0000_0002);
    endtask

    task automatic test_multi();
        run_case(7'h00, 6'h15, 10'h200, 2'h0, 3'h0, 0, 1);
        run_case(7'h00, 6'h3F, 10'h3BF, 2'h2, 3'h0, 0, 0);
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence: reset three cycles, then the scenarios
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_first();
        test_vector();
        test_miss();
        test_beat();
        test_multi();
        give_verdict();
    end

    // watchdog, far beyond the roughly 550 cycles the scenarios need
    initial
    begin
        #100000;
        error_cnt++;
        give_verdict();
    end
endmodule
